// ### core/gpmc_pkg.sv
package gpmc_pkg;

	// ==================================================
	// register map
	localparam logic [7:0] GPMC_ADDR_OUT_DIR = 8'h40;
	localparam logic [7:0] GPMC_ADDR_IN_LVL = 8'h41;
	localparam logic [7:0] GPMC_ADDR_MODE = 8'h70;

	// port_output_direction fields: data in low bits, direction above
	localparam int GPMC_OUT_DATA_LSB = 0;
	localparam int GPMC_OUT_DIR_LSB = 4;
	localparam logic [7:0] GPMC_OUT_DIR_RESET = 8'h30;

	// pin_and_pump_mode fields
	localparam int GPMC_MODE_REF_OUT = 0;
	localparam int GPMC_MODE_REF_IN = 1;
	localparam int GPMC_MODE_PUMP_OFF = 2;
	localparam int GPMC_MODE_PUMP_ON = 3;
	localparam logic [7:0] GPMC_MODE_RESET = 8'h00;
	localparam logic [7:0] GPMC_MODE_MASK = 8'h0f;

	// ==================================================
	// timing
	localparam int GPMC_CLK_PERIOD_NS = 40;
	localparam int GPMC_CLK_HZ = 25000000;
	localparam int GPMC_OSC_HZ = 4000000;
	localparam int GPMC_FUSE_TIME_US = 800;
	localparam int GPMC_STARTUP_TIME_US = 450;
	// longest times round down to whole cycles
	localparam int GPMC_FUSE_CYC = GPMC_FUSE_TIME_US * 1000 /
		GPMC_CLK_PERIOD_NS;
	localparam int GPMC_STARTUP_CYC = GPMC_STARTUP_TIME_US * 1000 /
		GPMC_CLK_PERIOD_NS;
	localparam int GPMC_OSC_STEP = GPMC_OSC_HZ / 1000000;
	localparam int GPMC_OSC_MOD = GPMC_CLK_HZ / 1000000;

	// ==================================================
	// types
	typedef enum logic [1:0] {
		GPMC_FUSE_LOAD,
		GPMC_SLEEP,
		GPMC_STARTUP,
		GPMC_ACTIVE
	} gpmc_state_t;

	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
		logic [1:0] in_en;
	} gpmc_pin_drive_t;

	typedef struct packed {
		logic ref_out;
		logic ref_in;
		logic pump_en;
		logic pump_bypass;
	} gpmc_analog_t;

endpackage

// ### core/gpmc_top.sv
`timescale 1ns/100ps
// What this block does
// - one direction bit per pin at 0x40
// - direction one enables input and output buffers
// - direction zero: input only, driver off
// - direction bits reset to one
// - read-only live pin levels at 0x41
// - input levels returned directly, no filtering
// - input buffer stays on while driving
// - drive low data bits; data resets zero
// - reference select bits bypass pin digital function
// - all four reference pin combinations supported
// - pump force off: pump disabled, supply through
// - pump force on wins over force off
// - 4 MHz master tick, divided for blocks
// - reset: run oscillator, load fuses, then sleep
// - reset to sleep within 800us
// - addressed bus traffic wakes oscillator from sleep
// - oscillator start-up done within 450us
// - no conversion start during start-up window
// - low address bits from pin levels
module gpmc_top
	import gpmc_pkg::*;
#(
	parameter int FUSE_CYC = GPMC_FUSE_CYC,
	parameter int STARTUP_CYC = GPMC_STARTUP_CYC,
	parameter int SUB_DIV = 4,
	parameter int PINS = 2
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register access from the serial-bus engine
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// port pins
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] pin_in_en,
	// analog and pump controls
	output logic reference_output_select,
	output logic reference_input_select,
	input wire logic pump_auto_req,
	output logic pump_enable,
	output logic pump_bypass,
	// fuse loading
	input wire logic [4:0] fuse_addr_hi,
	input wire logic fuse_done,
	output logic fuse_load_req,
	output logic [6:0] bus_address,
	// wake, sleep and conversion gating
	input wire logic bus_addr_match,
	input wire logic sleep_req,
	input wire logic conv_req,
	output logic conv_start,
	output logic osc_running,
	output logic osc_tick,
	output logic sub_tick,
	output logic startup_busy
);

	// ==================================================
	// elaboration checks
	if (PINS != 2) begin : g_bad_pins
		$error("gpmc_top serves exactly two pins");
	end
	if (FUSE_CYC < 1 || FUSE_CYC > 32767 || STARTUP_CYC < 1 ||
		STARTUP_CYC > 32767 || SUB_DIV < 1 || SUB_DIV > 255) begin : g_bad
		$error("gpmc_top count parameter out of range");
	end

	// ==================================================
	// registers
	logic [7:0] out_dir_reg, out_dir_next, mode_reg, mode_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [PINS-1:0] dir, dout, ref_sel;

	always_comb begin
		out_dir_next = out_dir_reg;
		mode_next = mode_reg;
		rdata_next = rdata_reg;
		rvalid_next = reg_rd;
		if (reg_wr && reg_addr == GPMC_ADDR_OUT_DIR) begin
			out_dir_next = reg_wdata;
		end
		// writes to the input level address are dropped
		if (reg_wr && reg_addr == GPMC_ADDR_MODE) begin
			mode_next = reg_wdata & GPMC_MODE_MASK;
		end
		if (reg_rd) begin
			unique case (reg_addr)
				GPMC_ADDR_OUT_DIR: rdata_next = out_dir_reg;
				// raw pin levels, unfiltered by design
				GPMC_ADDR_IN_LVL: rdata_next = {6'h00, pin_in};
				GPMC_ADDR_MODE: rdata_next = mode_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_dir_reg <= GPMC_OUT_DIR_RESET;
			mode_reg <= GPMC_MODE_RESET;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			out_dir_reg <= out_dir_next;
			mode_reg <= mode_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
	assign dir = out_dir_reg[GPMC_OUT_DIR_LSB +: PINS];
	assign dout = out_dir_reg[GPMC_OUT_DATA_LSB +: PINS];
	// pin zero carries reference out, pin one reference in
	assign ref_sel = {mode_reg[GPMC_MODE_REF_IN],
		mode_reg[GPMC_MODE_REF_OUT]};

	// ==================================================
	// pin drive, one slice per pin
	gpmc_pin_drive_t drv;
	gpmc_analog_t ana;

	for (genvar i = 0; i < PINS; i++) begin : g_pin
		// the input buffer stays on while driving so readback is real
		assign drv.in_en[i] = ~ref_sel[i];
		assign drv.oe[i] = dir[i] & ~ref_sel[i];
		assign drv.out[i] = dout[i] & drv.oe[i];
	end

	assign pin_out = drv.out;
	assign pin_oe = drv.oe;
	assign pin_in_en = drv.in_en;

	// ==================================================
	// reference and pump
	always_comb begin
		ana.ref_out = ref_sel[0];
		ana.ref_in = ref_sel[1];
		ana.pump_en = mode_reg[GPMC_MODE_PUMP_ON] |
			(~mode_reg[GPMC_MODE_PUMP_OFF] & pump_auto_req);
		ana.pump_bypass = ~ana.pump_en;
	end

	assign reference_output_select = ana.ref_out;
	assign reference_input_select = ana.ref_in;
	assign pump_enable = ana.pump_en;
	assign pump_bypass = ana.pump_bypass;

	// ==================================================
	// oscillator sequencing
	gpmc_state_t state_reg, state_next;
	logic [14:0] timer_reg, timer_next;
	logic [6:0] addr_reg, addr_next;

	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg + 15'h0001;
		addr_next = addr_reg;
		unique case (state_reg)
			GPMC_FUSE_LOAD: begin
				// hard bound so the sleep entry is never late
				if (fuse_done || timer_reg == 15'(FUSE_CYC - 1)) begin
					state_next = GPMC_SLEEP;
					addr_next = {fuse_addr_hi, pin_in};
					timer_next = 15'h0000;
				end
			end
			GPMC_SLEEP: begin
				timer_next = 15'h0000;
				if (bus_addr_match) begin
					state_next = GPMC_STARTUP;
				end
			end
			GPMC_STARTUP: begin
				if (timer_reg == 15'(STARTUP_CYC - 1)) begin
					state_next = GPMC_ACTIVE;
					timer_next = 15'h0000;
				end
			end
			GPMC_ACTIVE: begin
				timer_next = 15'h0000;
				if (sleep_req) begin
					state_next = GPMC_SLEEP;
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= GPMC_FUSE_LOAD;
			timer_reg <= 15'h0000;
			addr_reg <= 7'h00;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			addr_reg <= addr_next;
		end
	end

	assign bus_address = addr_reg;
	assign fuse_load_req = (state_reg == GPMC_FUSE_LOAD);
	assign osc_running = (state_reg != GPMC_SLEEP);
	assign startup_busy = (state_reg == GPMC_STARTUP);
	assign conv_start = conv_req & (state_reg == GPMC_ACTIVE);

	// ==================================================
	// master tick: 4 of every 25 cycles, then a divided tick
	logic [4:0] acc_reg, acc_next;
	logic [7:0] div_reg, div_next;
	logic tick_reg, tick_next, sub_reg, sub_next;

	always_comb begin
		acc_next = acc_reg;
		div_next = div_reg;
		tick_next = 1'b0;
		sub_next = 1'b0;
		// fractional step keeps the average rate exact
		if (osc_running) begin
			if (acc_reg + 5'(GPMC_OSC_STEP) >= 5'(GPMC_OSC_MOD)) begin
				acc_next = acc_reg + 5'(GPMC_OSC_STEP) -
					5'(GPMC_OSC_MOD);
				tick_next = 1'b1;
			end else begin
				acc_next = acc_reg + 5'(GPMC_OSC_STEP);
			end
			if (tick_next) begin
				if (div_reg == 8'(SUB_DIV - 1)) begin
					div_next = 8'h00;
					sub_next = 1'b1;
				end else begin
					div_next = div_reg + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_reg <= 5'h00;
			div_reg <= 8'h00;
			tick_reg <= 1'b0;
			sub_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			div_reg <= div_next;
			tick_reg <= tick_next;
			sub_reg <= sub_next;
		end
	end

	assign osc_tick = tick_reg;
	assign sub_tick = sub_reg;

	// ==================================================
	// checks
	property p_dir_drive;
		@(posedge clock) disable iff (rst)
		(dir[0] && !ref_sel[0]) |-> (pin_oe[0] && pin_in_en[0]);
	endproperty
	a_dir_drive: assert property (p_dir_drive)
		else $error("pin zero not driving with direction set");
	property p_dir_input;
		@(posedge clock) disable iff (rst)
		!dir[1] |-> (!pin_oe[1] && !pin_out[1]);
	endproperty
	a_dir_input: assert property (p_dir_input)
		else $error("pin one driving while input only");
	property p_reset_dir;
		@(posedge clock) $fell(rst) |-> (pin_oe == 2'h3 && pin_out == 2'h0);
	endproperty
	a_reset_dir: assert property (p_reset_dir)
		else $error("pins not in driven-low mode after reset");
	property p_in_read;
		@(posedge clock) disable iff (rst)
		(reg_rd && reg_addr == GPMC_ADDR_IN_LVL) |=>
			(reg_rvalid && reg_rdata == {6'h00, $past(pin_in)});
	endproperty
	a_in_read: assert property (p_in_read)
		else $error("input level read does not match pins");
	property p_out_data;
		@(posedge clock) disable iff (rst)
		(reg_wr && reg_addr == GPMC_ADDR_OUT_DIR &&
			reg_wdata[5:4] == 2'h3 && mode_reg[1:0] == 2'h0 &&
			!(reg_wr && reg_addr == GPMC_ADDR_MODE)) |=>
			pin_out == $past(reg_wdata[1:0]);
	endproperty
	a_out_data: assert property (p_out_data)
		else $error("pin data does not follow written value");
	property p_ref_off;
		@(posedge clock) disable iff (rst)
		reference_input_select |-> (!pin_oe[1] && !pin_in_en[1]);
	endproperty
	a_ref_off: assert property (p_ref_off)
		else $error("reference pin still driven digitally");
	property p_pump_on;
		@(posedge clock) disable iff (rst)
		mode_reg[GPMC_MODE_PUMP_ON] |-> (pump_enable && !pump_bypass);
	endproperty
	a_pump_on: assert property (p_pump_on)
		else $error("pump force on not honoured");
	property p_pump_off;
		@(posedge clock) disable iff (rst)
		(mode_reg[GPMC_MODE_PUMP_OFF] && !mode_reg[GPMC_MODE_PUMP_ON])
			|-> (pump_bypass && !pump_enable);
	endproperty
	a_pump_off: assert property (p_pump_off)
		else $error("pump force off not honoured");
	property p_fuse_bound;
		@(posedge clock) disable iff (rst)
		fuse_load_req |-> timer_reg < 15'(FUSE_CYC);
	endproperty
	a_fuse_bound: assert property (p_fuse_bound)
		else $error("fuse load overran its window");

	property p_wake;
		@(posedge clock) disable iff (rst)
		(!osc_running && bus_addr_match) |=> (osc_running && startup_busy);
	endproperty
	a_wake: assert property (p_wake)
		else $error("oscillator did not wake on addressed traffic");

	property p_startup_bound;
		@(posedge clock) disable iff (rst)
		startup_busy |-> timer_reg < 15'(STARTUP_CYC);
	endproperty
	a_startup_bound: assert property (p_startup_bound)
		else $error("start-up window overran");

	property p_no_conv;
		@(posedge clock) disable iff (rst)
		(startup_busy || !osc_running) |-> !conv_start;
	endproperty
	a_no_conv: assert property (p_no_conv)
		else $error("conversion started while oscillator not ready");

	property p_tick_gap;
		@(posedge clock) disable iff (rst)
		osc_tick |=> !osc_tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("master tick faster than divided rate");

	c_wake: cover property (@(posedge clock) disable iff (rst)
		startup_busy ##1 !startup_busy && osc_running);
	c_both_ref: cover property (@(posedge clock) disable iff (rst)
		reference_output_select && reference_input_select);
	c_conv: cover property (@(posedge clock) disable iff (rst) conv_start);
	c_sleep: cover property (@(posedge clock) disable iff (rst)
		$fell(osc_running));

endmodule

// ### dv/gpmc_pin_partner.sv
`timescale 1ns/100ps
// ==================================================
// sensor side of the two port pins
module gpmc_pin_partner (
	// clock
	input wire logic clock,
	// from the port
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	// external drive set by the bench
	input wire logic [1:0] ext_en,
	input wire logic [1:0] ext_val,
	// level seen by the input buffers
	output logic [1:0] pin_in
);
	logic [1:0] float_reg = 2'h0;

	// ==================================================
	// wire level
	// a floating pin has no pull, so it never holds a stable value
	always_ff @(posedge clock) begin
		float_reg <= ~pin_in;
	end
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (pin_oe[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_val[i];
			end else begin
				pin_in[i] = float_reg[i];
			end
		end
	end
endmodule

// ### dv/gpio_pin_mode_and_power_ctrl_tb.sv
`timescale 1ns/100ps
module gpio_pin_mode_and_power_ctrl_tb;
	import gpmc_pkg::*;
	localparam int SCYC = 10;
	localparam int FCYC = 20;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
	logic [1:0] pin_in, pin_out, pin_oe, pin_in_en;
	logic [1:0] ext_en = 2'h3, ext_val = 2'h2;
	logic ref_o, ref_i, pump_auto_req = 1'b0, pump_enable, pump_bypass;
	logic fuse_done = 1'b0, fuse_load_req, bus_addr_match = 1'b0;
	logic conv_req = 1'b0, conv_start, osc_running, osc_tick, sub_tick;
	logic startup_busy, sleep_req = 1'b0;
	logic [6:0] bus_address;
	int n_mismatch = 0;
	int total_checks = 0;

	// ==================================================
	// design and pin side
	gpmc_top #(.FUSE_CYC(FCYC), .STARTUP_CYC(SCYC)) u_dut (
		.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in_en(pin_in_en),
		.reference_output_select(ref_o), .reference_input_select(ref_i),
		.pump_auto_req(pump_auto_req), .pump_enable(pump_enable),
		.pump_bypass(pump_bypass), .fuse_addr_hi(5'h15),
		.fuse_done(fuse_done), .fuse_load_req(fuse_load_req),
		.bus_address(bus_address), .bus_addr_match(bus_addr_match),
		.sleep_req(sleep_req), .conv_req(conv_req), .conv_start(conv_start),
		.osc_running(osc_running), .osc_tick(osc_tick),
		.sub_tick(sub_tick), .startup_busy(startup_busy));
	gpmc_pin_partner u_pins (.clock(clock), .pin_out(pin_out),
		.pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
		.pin_in(pin_in));

	initial begin
		forever #20 clock = ~clock;
	end

	// ==================================================
	// shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string msg);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got,
				exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk(8'(reg_rvalid), 8'h01, "read answer");
		chk(reg_rdata, exp, "read data");
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==================================================
	// scenarios
	task automatic t_reset();
		chk(8'(pin_oe), 8'h03, "oe at reset");
		chk(8'(pin_out), 8'h00, "data at reset");
		chk(8'(fuse_load_req), 8'h01, "fuse load");
		rd(GPMC_ADDR_OUT_DIR, 8'h30);
		rd(GPMC_ADDR_MODE, 8'h00);
		// release the pins so the address straps reach the input buffers
		wr(GPMC_ADDR_OUT_DIR, 8'h00);
		@(posedge clock);
		fuse_done <= 1'b1;
		@(posedge clock);
		fuse_done <= 1'b0;
		@(negedge clock);
		chk(8'(bus_address), 8'h56, "address");
		chk(8'(osc_running), 8'h00, "asleep");
	endtask
	task automatic t_dir();
		@(posedge clock);
		ext_val <= 2'h0;
		wr(GPMC_ADDR_OUT_DIR, 8'h11);
		chk(8'(pin_oe), 8'h01, "oe");
		chk(8'(pin_out), 8'h01, "drive");
		chk(8'(pin_in_en), 8'h03, "input buffers");
		rd(GPMC_ADDR_IN_LVL, 8'h01);
		wr(GPMC_ADDR_IN_LVL, 8'hff);
		rd(GPMC_ADDR_OUT_DIR, 8'h11);
		@(posedge clock);
		ext_val <= 2'h2;
		rd(GPMC_ADDR_IN_LVL, 8'h03);
	endtask
	task automatic t_ref();
		logic [1:0] oe;
		wr(GPMC_ADDR_OUT_DIR, 8'h33);
		for (int k = 0; k < 4; k++) begin
			wr(GPMC_ADDR_MODE, 8'(k));
			oe = 2'h3 & ~2'(k);
			chk(8'(pin_oe), 8'(oe), "ref oe");
			chk(8'(pin_out), 8'(oe), "ref drive");
			chk(8'(pin_in_en), 8'(2'h3 ^ 2'(k)), "ref buffer");
			chk(8'({ref_i, ref_o}), 8'(k), "ref select");
			rd(GPMC_ADDR_MODE, 8'(k));
		end
	endtask
	task automatic t_pump();
		logic en;
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			pump_auto_req <= i[2];
			wr(GPMC_ADDR_MODE, 8'(i[1:0]) << 2);
			en = i[1] | (~i[0] & i[2]);
			chk(8'(pump_enable), 8'(en), "pump");
			chk(8'(pump_bypass), 8'(!en), "bypass");
		end
	endtask
	task automatic t_wake();
		int o;
		int s;
		o = 0;
		s = 0;
		@(posedge clock);
		conv_req <= 1'b1;
		@(negedge clock);
		chk(8'(conv_start), 8'h00, "asleep conv");
		@(posedge clock);
		bus_addr_match <= 1'b1;
		@(posedge clock);
		bus_addr_match <= 1'b0;
		@(negedge clock);
		chk(8'(osc_running), 8'h01, "wake");
		chk(8'(startup_busy), 8'h01, "start");
		repeat (SCYC - 1) begin
			@(negedge clock);
			chk(8'({startup_busy, conv_start}), 8'h02, "window");
		end
		@(negedge clock);
		chk(8'({startup_busy, conv_start}), 8'h01, "ready");
		@(posedge clock);
		conv_req <= 1'b0;
		repeat (100) begin
			@(negedge clock);
			o += int'(osc_tick === 1'b1);
			s += int'(sub_tick === 1'b1);
		end
		chk(8'(o), 8'h10, "osc ticks");
		chk(8'(s), 8'h04, "sub ticks");
		// back to sleep: conversions must be gated off again
		@(posedge clock);
		sleep_req <= 1'b1;
		conv_req <= 1'b1;
		@(posedge clock);
		sleep_req <= 1'b0;
		@(negedge clock);
		chk(8'({osc_running, conv_start}), 8'h00, "back asleep");
		@(posedge clock);
		conv_req <= 1'b0;
	endtask
	task automatic t_refuse();
		int n;
		n = 0;
		// mid-run reset; no fuse_done, so the hard bound ends the load
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk(8'(pin_oe), 8'h03, "oe after reset");
		chk(8'({fuse_load_req, osc_running}), 8'h03, "fuse rerun");
		while (osc_running === 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		chk(8'(n), 8'(FCYC), "fuse window");
		// pins driven low from reset, so the low address bits are zero
		chk(8'(bus_address), 8'h54, "driven address");
	endtask

	// ==================================================
	// run
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		t_reset();
		t_dir();
		t_ref();
		t_pump();
		t_wake();
		t_refuse();
		conclude();
	end
	// the whole run is a few hundred cycles; this only cuts a hang
	initial begin
		repeat (3000) @(posedge clock);
		n_mismatch++;
		conclude();
	end
endmodule
